// File: hdl/dca_top.sv
// Four-channel DMA address and count store with shared status and a transfer issuer.
// Assumes an Avalon-MM master with word addressing and a mover that acknowledges each item.
//
// The Avalon-MM slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module dca_top #(
  parameter int STEP_SHIFT = dca_pkg::STEP_SHIFT_DEF
) (
  input  wire logic                       mclk,
  input  wire logic                       srst,
  input  wire logic [dca_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [dca_pkg::DATA_W-1:0] avs_writedata,
  output logic      [dca_pkg::DATA_W-1:0] avs_readdata,
  output logic                            avs_waitrequest,
  input  wire logic [dca_pkg::NUM_CH-1:0] chan_req,
  input  wire logic [dca_pkg::NUM_CH-1:0] per_wr_collision,
  output dca_pkg::dca_xfer_s              xfer,
  input  wire logic                       xfer_ack,
  output logic                            irq
);

  localparam int N = dca_pkg::NUM_CH;

  if (N != 4 || STEP_SHIFT < 0 || STEP_SHIFT > 2) begin : g_check
    $error("dca_top: four channels and a step shift of 0 to 2 are supported");
  end

  // Lowest channel number wins; fixed priority
  function automatic logic [1:0] pick_lowest(input logic [N-1:0] req);
    logic [1:0] sel;
    sel = 2'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        sel = 2'(i);
      end
    end
    return sel;
  endfunction : pick_lowest

  function automatic logic [N-1:0] one_hot(input logic [1:0] sel);
    logic [N-1:0] v;
    v = '0;
    v[sel] = 1'b1;
    return v;
  endfunction : one_hot

  // Register storage
  dca_pkg::dca_ctrl_s              ctrl       [N];
  logic [dca_pkg::RAM_AW-1:0]      pri_base   [N];
  logic [dca_pkg::RAM_AW-1:0]      sec_base   [N];
  logic [dca_pkg::PER_AW-1:0]      per_target [N];
  logic [dca_pkg::CNT_W-1:0]       xfer_cnt   [N];
  logic [N-1:0]                    force_bit;
  logic [dca_pkg::RAM_AW-1:0]      recent_ram_address;
  logic [N-1:0]                    write_collision_flag;
  logic [N-1:0]                    request_collision_flag;
  logic [dca_pkg::LCA_W-1:0]       last_active_channel;
  logic [dca_pkg::INT_W-1:0]       int_stat;
  logic [dca_pkg::INT_W-1:0]       int_mask;
  dca_pkg::dca_state_e             state;

  // Channel engine outputs
  logic [N-1:0]                    pend;
  logic [dca_pkg::RAM_AW-1:0]      cur_addr   [N];
  logic [N-1:0]                    buffer_select_flag;
  logic [N-1:0]                    evt_half;
  logic [N-1:0]                    evt_full;
  logic [N-1:0]                    oneshot_end;
  logic [N-1:0]                    force_done;

  // Bus decode
  wire                             wr_go;
  wire                             rd_go;
  wire                             is_chan;
  wire [1:0]                       sel_ch;
  wire [2:0]                       sel_reg;
  wire [N-1:0]                     ch_hit;
  wire [N-1:0]                     force_wr;
  wire [N-1:0]                     grant;
  wire [N-1:0]                     blk_evt;
  wire [N-1:0]                     rq_evt;
  wire [1:0]                       pick;
  wire [dca_pkg::INT_W-1:0]        int_set;
  wire [dca_pkg::INT_W-1:0]        int_clr;
  logic [dca_pkg::DATA_W-1:0]      next_readdata;

  // Write lands at the edge where waitrequest is seen low
  assign wr_go   = avs_write & ~avs_waitrequest;
  assign rd_go   = avs_read & avs_waitrequest;
  assign is_chan = ~avs_address[dca_pkg::ADDR_W-1];
  assign sel_ch  = avs_address[4:3];
  assign sel_reg = avs_address[2:0];
  assign ch_hit  = (wr_go && is_chan) ? one_hot(sel_ch) : '0;
  assign force_wr = (sel_reg == dca_pkg::REG_CTRL && avs_writedata[dca_pkg::CTRL_FORCE])
                    ? ch_hit : '0;
  assign grant   = (state == dca_pkg::ST_BUSY && xfer_ack) ? one_hot(xfer.chan) : '0;
  assign pick    = pick_lowest(pend);

  // Channel event counts as full or half block by its select bit
  for (genvar c = 0; c < N; c++) begin : g_ch
    assign blk_evt[c] = ctrl[c].half ? evt_half[c] : evt_full[c];
    // Forced and peripheral request meeting on one channel
    assign rq_evt[c]  = chan_req[c] & ctrl[c].en & (force_bit[c] | force_wr[c]);

    dca_chan #(
      .STEP_SHIFT (STEP_SHIFT)
    ) u_chan (
      .mclk        (mclk),
      .srst        (srst),
      .cfg         (ctrl[c]),
      .force_req   (force_bit[c]),
      .per_req     (chan_req[c]),
      .grant       (grant[c]),
      .count       (xfer_cnt[c]),
      .pri_base    (pri_base[c]),
      .sec_base    (sec_base[c]),
      .pending     (pend[c]),
      .ram_addr    (cur_addr[c]),
      .buf_sel     (buffer_select_flag[c]),
      .evt_half    (evt_half[c]),
      .evt_full    (evt_full[c]),
      .oneshot_end (oneshot_end[c]),
      .force_done  (force_done[c])
    );
  end

  assign int_set = {rq_evt, per_wr_collision, blk_evt};
  assign int_clr = (wr_go && avs_address == dca_pkg::SH_INT_STAT)
                   ? avs_writedata[dca_pkg::INT_W-1:0] : '0;

  // Read mux; unmapped words read zero
  always_comb begin
    next_readdata = '0;
    if (is_chan) begin
      if (sel_reg == dca_pkg::REG_CTRL) begin
        next_readdata[dca_pkg::CTRL_EN]      = ctrl[sel_ch].en;
        next_readdata[dca_pkg::CTRL_DIR]     = ctrl[sel_ch].dir;
        next_readdata[dca_pkg::CTRL_HALF]    = ctrl[sel_ch].half;
        next_readdata[dca_pkg::CTRL_PP]      = ctrl[sel_ch].pp;
        next_readdata[dca_pkg::CTRL_ONESHOT] = ctrl[sel_ch].oneshot;
        next_readdata[dca_pkg::CTRL_FORCE]   = force_bit[sel_ch];
      end else if (sel_reg == dca_pkg::REG_PRI_HI) begin
        next_readdata[7:0] = pri_base[sel_ch][23:16];
      end else if (sel_reg == dca_pkg::REG_PRI_LO) begin
        next_readdata[15:0] = pri_base[sel_ch][15:0];
      end else if (sel_reg == dca_pkg::REG_SEC_HI) begin
        next_readdata[7:0] = sec_base[sel_ch][23:16];
      end else if (sel_reg == dca_pkg::REG_SEC_LO) begin
        next_readdata[15:0] = sec_base[sel_ch][15:0];
      end else if (sel_reg == dca_pkg::REG_PAD) begin
        next_readdata[15:0] = per_target[sel_ch];
      end else if (sel_reg == dca_pkg::REG_CNT) begin
        next_readdata[dca_pkg::CNT_W-1:0] = xfer_cnt[sel_ch];
      end
    end else if (avs_address == dca_pkg::SH_RECENT_HI) begin
      next_readdata[7:0] = recent_ram_address[23:16];
    end else if (avs_address == dca_pkg::SH_RECENT_LO) begin
      next_readdata[15:0] = recent_ram_address[15:0];
    end else if (avs_address == dca_pkg::SH_WCOL) begin
      next_readdata[dca_pkg::STAT_W-1:0] = write_collision_flag;
    end else if (avs_address == dca_pkg::SH_REQ_COL) begin
      next_readdata[dca_pkg::STAT_W-1:0] = request_collision_flag;
    end else if (avs_address == dca_pkg::SH_LCA) begin
      next_readdata[dca_pkg::LCA_W-1:0] = last_active_channel;
    end else if (avs_address == dca_pkg::SH_PPS) begin
      next_readdata[dca_pkg::STAT_W-1:0] = buffer_select_flag;
    end else if (avs_address == dca_pkg::SH_INT_STAT) begin
      next_readdata[dca_pkg::INT_W-1:0] = int_stat;
    end else if (avs_address == dca_pkg::SH_INT_MASK) begin
      next_readdata[dca_pkg::INT_W-1:0] = int_mask;
    end
  end

  // One wait cycle per access, then a single answer cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (rd_go) begin
        avs_readdata <= next_readdata;
      end
    end
  end

  // Channel registers; software must not rewrite address or count while enabled
  always_ff @(posedge mclk) begin
    for (int c = 0; c < N; c++) begin
      if (srst) begin
        ctrl[c]       <= '0;
        pri_base[c]   <= '0;
        sec_base[c]   <= '0;
        per_target[c] <= '0;
        xfer_cnt[c]   <= '0;
      end else if (ch_hit[c]) begin
        if (sel_reg == dca_pkg::REG_CTRL) begin
          ctrl[c].en      <= avs_writedata[dca_pkg::CTRL_EN];
          ctrl[c].dir     <= avs_writedata[dca_pkg::CTRL_DIR];
          ctrl[c].half    <= avs_writedata[dca_pkg::CTRL_HALF];
          ctrl[c].pp      <= avs_writedata[dca_pkg::CTRL_PP];
          ctrl[c].oneshot <= avs_writedata[dca_pkg::CTRL_ONESHOT];
        end else if (sel_reg == dca_pkg::REG_PRI_HI) begin
          pri_base[c][23:16] <= avs_writedata[7:0];
        end else if (sel_reg == dca_pkg::REG_PRI_LO) begin
          pri_base[c][15:0] <= avs_writedata[15:0];
        end else if (sel_reg == dca_pkg::REG_SEC_HI) begin
          sec_base[c][23:16] <= avs_writedata[7:0];
        end else if (sel_reg == dca_pkg::REG_SEC_LO) begin
          sec_base[c][15:0] <= avs_writedata[15:0];
        end else if (sel_reg == dca_pkg::REG_PAD) begin
          per_target[c] <= avs_writedata[15:0];
        end else if (sel_reg == dca_pkg::REG_CNT) begin
          xfer_cnt[c] <= avs_writedata[dca_pkg::CNT_W-1:0];
        end
      end else if (oneshot_end[c]) begin
        ctrl[c].en <= 1'b0;
      end
    end
  end

  // Force: software sets only; cleared on completion or disable, set wins
  always_ff @(posedge mclk) begin
    if (srst) begin
      force_bit <= '0;
    end else begin
      for (int c = 0; c < N; c++) begin
        if (force_wr[c]) begin
          force_bit[c] <= 1'b1;
        end else if (!ctrl[c].en || force_done[c]) begin
          force_bit[c] <= 1'b0;
        end
      end
    end
  end

  // Collision flags hold until the channel is disabled; a new event wins
  always_ff @(posedge mclk) begin
    if (srst) begin
      write_collision_flag   <= '0;
      request_collision_flag <= '0;
    end else begin
      for (int c = 0; c < N; c++) begin
        if (per_wr_collision[c]) begin
          write_collision_flag[c] <= 1'b1;
        end else if (!ctrl[c].en) begin
          write_collision_flag[c] <= 1'b0;
        end
        if (rq_evt[c]) begin
          request_collision_flag[c] <= 1'b1;
        end else if (!ctrl[c].en) begin
          request_collision_flag[c] <= 1'b0;
        end
      end
    end
  end

  // Interrupt status: write one to clear, a same-cycle event wins
  always_ff @(posedge mclk) begin
    if (srst) begin
      int_stat <= '0;
      int_mask <= '0;
      irq      <= 1'b0;
    end else begin
      int_stat <= (int_stat & ~int_clr) | int_set;
      irq      <= |(int_stat & int_mask);
      if (wr_go && avs_address == dca_pkg::SH_INT_MASK) begin
        int_mask <= avs_writedata[dca_pkg::INT_W-1:0];
      end
    end
  end

  // Issuer: one item outstanding; the mover sees a stable request until ack
  always_ff @(posedge mclk) begin
    if (srst) begin
      state               <= dca_pkg::ST_IDLE;
      xfer                <= '0;
      recent_ram_address  <= '0;
      last_active_channel <= dca_pkg::LCA_NONE;
    end else begin
      case (state)
        dca_pkg::ST_IDLE: begin
          if (|pend) begin
            xfer.valid    <= 1'b1;
            xfer.chan     <= pick;
            xfer.dir      <= ctrl[pick].dir;
            xfer.ram_addr <= cur_addr[pick];
            xfer.per_addr <= per_target[pick];
            state         <= dca_pkg::ST_BUSY;
          end
        end
        dca_pkg::ST_BUSY: begin
          if (xfer_ack) begin
            xfer.valid          <= 1'b0;
            recent_ram_address  <= xfer.ram_addr;
            last_active_channel <= {2'h0, xfer.chan};
            state               <= dca_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= dca_pkg::ST_IDLE;
        end
      endcase
    end
  end

endmodule : dca_top

// File: include/dca_pkg.sv
// Package for the four-channel DMA address, count and shared status block.
// Assumes a single 50 MHz clock domain and Avalon-MM word addressing.
package dca_pkg;

  localparam int NUM_CH  = 4;
  localparam int ADDR_W  = 6;
  localparam int DATA_W  = 32;
  localparam int RAM_AW  = 24;
  localparam int PER_AW  = 16;
  localparam int CNT_W   = 14;
  localparam int LCA_W   = 4;
  localparam int STAT_W  = 4;
  localparam int HALF_W  = 16;

  // Per-channel word index inside a channel slot
  localparam logic [2:0] REG_CTRL    = 3'h0;
  localparam logic [2:0] REG_PRI_HI  = 3'h1;
  localparam logic [2:0] REG_PRI_LO  = 3'h2;
  localparam logic [2:0] REG_SEC_HI  = 3'h3;
  localparam logic [2:0] REG_SEC_LO  = 3'h4;
  localparam logic [2:0] REG_PAD     = 3'h5;
  localparam logic [2:0] REG_CNT     = 3'h6;

  // Shared word addresses
  localparam logic [ADDR_W-1:0] SH_RECENT_HI = 6'h20;
  localparam logic [ADDR_W-1:0] SH_RECENT_LO = 6'h21;
  localparam logic [ADDR_W-1:0] SH_WCOL      = 6'h22;
  localparam logic [ADDR_W-1:0] SH_REQ_COL   = 6'h23;
  localparam logic [ADDR_W-1:0] SH_LCA       = 6'h24;
  localparam logic [ADDR_W-1:0] SH_PPS       = 6'h25;
  localparam logic [ADDR_W-1:0] SH_INT_STAT  = 6'h26;
  localparam logic [ADDR_W-1:0] SH_INT_MASK  = 6'h27;

  // Control register fields
  localparam int CTRL_EN      = 0;
  localparam int CTRL_DIR     = 1;
  localparam int CTRL_HALF    = 2;
  localparam int CTRL_PP      = 3;
  localparam int CTRL_ONESHOT = 4;
  localparam int CTRL_FORCE   = 8;

  // Interrupt status layout
  localparam int INT_BLK_LSB   = 0;
  localparam int INT_WCOL_LSB  = 4;
  localparam int INT_REQ_COL_LSB = 8;
  localparam int INT_W         = 12;

  localparam logic [LCA_W-1:0] LCA_NONE = 4'hf;
  localparam int               STEP_SHIFT_DEF = 1;

  typedef struct packed {
    logic en;
    logic dir;
    logic half;
    logic pp;
    logic oneshot;
  } dca_ctrl_s;

  typedef struct packed {
    logic              valid;
    logic [1:0]        chan;
    logic              dir;
    logic [RAM_AW-1:0] ram_addr;
    logic [PER_AW-1:0] per_addr;
  } dca_xfer_s;

  typedef enum logic {
    ST_IDLE,
    ST_BUSY
  } dca_state_e;

endpackage : dca_pkg

// File: hdl/dca_chan.sv
// One channel's block sequencer: item index, buffer select and block events.
// Assumes grant pulses only while the top has this channel's transfer acknowledged.
`timescale 1ns/10ps
module dca_chan #(
  parameter int STEP_SHIFT = dca_pkg::STEP_SHIFT_DEF
) (
  input  wire logic                       mclk,
  input  wire logic                       srst,
  input  wire dca_pkg::dca_ctrl_s         cfg,
  input  wire logic                       force_req,
  input  wire logic                       per_req,
  input  wire logic                       grant,
  input  wire logic [dca_pkg::CNT_W-1:0]  count,
  input  wire logic [dca_pkg::RAM_AW-1:0] pri_base,
  input  wire logic [dca_pkg::RAM_AW-1:0] sec_base,
  output logic                            pending,
  output logic [dca_pkg::RAM_AW-1:0]      ram_addr,
  output logic                            buf_sel,
  output logic                            evt_half,
  output logic                            evt_full,
  output logic                            oneshot_end,
  output logic                            force_done
);

  logic                       req_latch;
  logic [dca_pkg::CNT_W-1:0]  idx;
  wire                        last_item;
  wire                        half_item;
  wire [dca_pkg::RAM_AW-1:0]  base;

  assign last_item   = (idx == count);
  assign half_item   = (idx == (count >> 1));
  assign base        = buf_sel ? sec_base : pri_base;
  assign ram_addr    = base + (dca_pkg::RAM_AW'(idx) << STEP_SHIFT);
  assign pending     = cfg.en & (req_latch | force_req);
  assign force_done  = grant & force_req;

  always_ff @(posedge mclk) begin
    if (srst || !cfg.en) begin
      req_latch <= 1'b0;
    end else if (per_req) begin
      req_latch <= 1'b1;
    end else if (grant) begin
      req_latch <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    evt_half    <= grant & half_item;
    evt_full    <= grant & last_item;
    oneshot_end <= grant & last_item & cfg.oneshot & (!cfg.pp | buf_sel);
    if (srst) begin
      idx     <= '0;
      buf_sel <= 1'b0;
    end else if (!cfg.en) begin
      idx <= '0;
    end else if (grant) begin
      if (last_item) begin
        idx <= '0;
        if (cfg.pp) begin
          buf_sel <= ~buf_sel;
        end
      end else begin
        idx <= idx + 1'b1;
      end
    end
  end

endmodule : dca_chan

// File: verification/dca_top_sva.sv
// Checker for the DMA address, count and status block, bound to its top.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
module dca_top_sva #(
  parameter int STEP_SHIFT = dca_pkg::STEP_SHIFT_DEF
) (
  input wire logic                       mclk,
  input wire logic                       srst,
  input wire logic [dca_pkg::ADDR_W-1:0] avs_address,
  input wire logic                       avs_read,
  input wire logic                       avs_write,
  input wire logic [dca_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [dca_pkg::DATA_W-1:0] avs_readdata,
  input wire logic                       avs_waitrequest,
  input wire logic [dca_pkg::NUM_CH-1:0] chan_req,
  input wire logic [dca_pkg::NUM_CH-1:0] per_wr_collision,
  input wire dca_pkg::dca_xfer_s         xfer,
  input wire logic                       xfer_ack,
  input wire logic                       irq
);
  // Read data is only meaningful at the edge that ends the wait
  wire rd_done = avs_read && !avs_waitrequest;
  wire is_stat = avs_address inside {dca_pkg::SH_WCOL, dca_pkg::SH_REQ_COL, dca_pkg::SH_PPS};
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest not low one cycle after request");
  a_wait_idle_high: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("waitrequest low without a request");
  a_xfer_held: assert property (xfer.valid && !xfer_ack |=> xfer.valid && $stable(xfer))
    else $error("transfer fields changed before acknowledge");
  a_valid_drops: assert property (xfer.valid && xfer_ack |=> !xfer.valid)
    else $error("transfer still valid after acknowledge");
  a_count_upper_zero: assert property (rd_done && !avs_address[5] && avs_address[2:0] == 3'h6
    |-> avs_readdata[31:14] == 18'h0)
    else $error("count upper bits not zero");
  a_base_high_zero: assert property (rd_done && !avs_address[5]
    && avs_address[2:0] inside {3'h1, 3'h3} |-> avs_readdata[31:8] == 24'h0)
    else $error("base high word upper bits not zero");
  a_recent_high_zero: assert property (rd_done && avs_address == dca_pkg::SH_RECENT_HI
    |-> avs_readdata[31:8] == 24'h0)
    else $error("recent address high upper bits not zero");
  a_status_upper_zero: assert property (rd_done && is_stat |-> avs_readdata[31:4] == 28'h0)
    else $error("status upper bits not zero");
  a_last_chan_code: assert property (rd_done && avs_address == dca_pkg::SH_LCA
    |-> avs_readdata inside {32'h0, 32'h1, 32'h2, 32'h3, 32'hf})
    else $error("last channel code out of range");
  a_unmapped_zero: assert property (rd_done && ((!avs_address[5] && avs_address[2:0] == 3'h7)
    || avs_address > 6'h27) |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
endmodule : dca_top_sva

bind dca_top dca_top_sva #(.STEP_SHIFT(STEP_SHIFT)) u_sva (
  .mclk(mclk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .chan_req(chan_req), .per_wr_collision(per_wr_collision),
  .xfer(xfer), .xfer_ack(xfer_ack), .irq(irq)
);

// File: verification/dca_mover.sv
// Model of the RAM and peripheral mover that answers each transfer item.
// Assumes items are offered one at a time and held until acknowledged.
`timescale 1ns/10ps
module dca_mover (
  input  wire logic               mclk,
  input  wire logic               srst,
  input  wire dca_pkg::dca_xfer_s xfer,
  output logic                    xfer_ack
);
  logic [1:0] wait_left;
  // Random 0..3 cycle stall so both prompt and slow answers occur
  always_ff @(posedge mclk) begin
    if (srst) begin
      xfer_ack  <= 1'b0;
      wait_left <= 2'h0;
    end else if (xfer_ack) begin
      xfer_ack <= 1'b0;
    end else if (xfer.valid) begin
      if (wait_left == 2'h0) begin
        xfer_ack  <= 1'b1;
        wait_left <= 2'($urandom_range(3));
      end else begin
        wait_left <= wait_left - 2'h1;
      end
    end
  end
endmodule : dca_mover

// File: verification/dma_channel_address_status_bench.sv
// Self-checking bench for the DMA address, count and status block.
// Assumes the mover model answers every item; reads are scored from a queue.
`timescale 1ns/10ps
module dma_channel_address_status_bench;
  localparam int SH = 1;
  logic               mclk, srst, avs_read, avs_write, xfer_ack, irq, avs_waitrequest;
  logic [5:0]         avs_address;
  logic [31:0]        avs_writedata, avs_readdata;
  logic [3:0]         chan_req, per_wr_collision;
  dca_pkg::dca_xfer_s xfer;
  int                 fails, checks_done;
  logic [31:0]        rd_q[$];
  string              rd_n[$];
  dca_pkg::dca_xfer_s x_q[$];
  logic [23:0]        pb[4], sb[4];
  logic [15:0]        pad[4];

  dca_top #(.STEP_SHIFT(SH)) DUT (.mclk(mclk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .chan_req(chan_req),
    .per_wr_collision(per_wr_collision), .xfer(xfer), .xfer_ack(xfer_ack), .irq(irq));
  dca_mover u_mover (.mclk(mclk), .srst(srst), .xfer(xfer), .xfer_ack(xfer_ack));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task cmp_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp_word

  task cmp_xfer(input dca_pkg::dca_xfer_s exp, input dca_pkg::dca_xfer_s got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value xfer expected %h seen %h", exp, got);
    end
  endtask : cmp_xfer

  function automatic logic [5:0] ra(input int c, input logic [2:0] r);
    return {c[2:0], r};
  endfunction : ra

  // Holds the request until waitrequest is seen low, then releases
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    // No cycle limit here; only the watchdog ends a stuck wait
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task rd(input logic [5:0] a, input logic [31:0] exp, input string name);
    rd_q.push_back(exp);
    rd_n.push_back(name);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task expect_x(input int c, input logic [23:0] a);
    x_q.push_back('{1'b1, c[1:0], c[0], a, pad[c]});
  endtask : expect_x

  task wait_x;
    int n;
    n = 0;
    while (x_q.size() != 0 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    if (x_q.size() != 0) fails++;
  endtask : wait_x

  task item(input int c);
    @(posedge mclk);
    chan_req <= 4'(1 << c);
    @(posedge mclk);
    chan_req <= 4'h0;
    wait_x();
  endtask : item

  // Scoreboard side: each completed read or item takes the oldest note
  always @(posedge mclk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (rd_q.size() == 0) fails++;
      else cmp_word(rd_n.pop_front(), rd_q.pop_front(), avs_readdata);
    end
    if (xfer.valid === 1'b1 && xfer_ack === 1'b1) begin
      if (x_q.size() == 0) fails++;
      else cmp_xfer(x_q.pop_front(), xfer);
    end
  end

  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    finish_test();
  end

  initial begin
    void'($urandom(32'h339b3307));
    {srst, avs_read, avs_write, avs_address, avs_writedata} = {3'b100, 38'h0};
    {chan_req, per_wr_collision} = 8'h0;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    rd(dca_pkg::SH_LCA, 32'hf, "last channel");
    rd(dca_pkg::SH_PPS, 32'h0, "buffer select");
    rd(dca_pkg::SH_RECENT_LO, 32'h0, "recent low");
    rd(dca_pkg::SH_WCOL, 32'h0, "write collision");
    rd(dca_pkg::SH_REQ_COL, 32'h0, "request collision");
    for (int c = 0; c < 4; c++) begin
      pb[c] = 24'($urandom());
      sb[c] = 24'($urandom());
      pad[c] = 16'($urandom());
      bus(1'b1, ra(c, 3'h1), {24'($urandom()), pb[c][23:16]});
      bus(1'b1, ra(c, 3'h2), {16'($urandom()), pb[c][15:0]});
      bus(1'b1, ra(c, 3'h3), {24'($urandom()), sb[c][23:16]});
      bus(1'b1, ra(c, 3'h4), {16'($urandom()), sb[c][15:0]});
      bus(1'b1, ra(c, 3'h5), {16'($urandom()), pad[c]});
      bus(1'b1, ra(c, 3'h6), 32'hffffc000 | 32'(c));
      rd(ra(c, 3'h1), {24'h0, pb[c][23:16]}, "primary high");
      rd(ra(c, 3'h2), {16'h0, pb[c][15:0]}, "primary low");
      rd(ra(c, 3'h3), {24'h0, sb[c][23:16]}, "secondary high");
      rd(ra(c, 3'h4), {16'h0, sb[c][15:0]}, "secondary low");
      rd(ra(c, 3'h5), {16'h0, pad[c]}, "peripheral address");
      rd(ra(c, 3'h6), 32'(c), "count");
      // Enable last, never rewriting address or count while live
      bus(1'b1, ra(c, 3'h0), 32'h9 | 32'(c[0] << 1));
      for (int i = 0; i <= c; i++) begin
        expect_x(c, pb[c] + 24'(i << SH));
        item(c);
      end
      rd(dca_pkg::SH_LCA, 32'(c), "last channel");
    end
    rd(dca_pkg::SH_PPS, 32'hf, "buffer select");
    // Carry from the low word must reach the high byte
    rd(dca_pkg::SH_RECENT_HI, {24'h0, 8'((pb[3] + 24'(3 << SH)) >> 16)}, "recent high");
    rd(dca_pkg::SH_RECENT_LO, {16'h0, 16'(pb[3] + 24'(3 << SH))}, "recent low");
    for (int i = 0; i <= 3; i++) begin
      expect_x(3, sb[3] + 24'(i << SH));
      item(3);
    end
    rd(dca_pkg::SH_PPS, 32'h7, "buffer select");
    expect_x(2, sb[2]);
    bus(1'b1, ra(2, 3'h0), 32'h109);
    wait_x();
    rd(ra(2, 3'h0), 32'h9, "control");
    rd(dca_pkg::SH_RECENT_LO, {16'h0, sb[2][15:0]}, "recent low");
    bus(1'b1, dca_pkg::SH_LCA, 32'h0);
    rd(dca_pkg::SH_LCA, 32'h2, "last channel");
    bus(1'b1, 6'h2f, 32'hffffffff);
    rd(6'h2f, 32'h0, "unmapped");
    rd(6'h07, 32'h0, "unmapped");
    @(posedge mclk);
    per_wr_collision <= 4'h8;
    @(posedge mclk);
    per_wr_collision <= 4'h0;
    rd(dca_pkg::SH_WCOL, 32'h8, "write collision");
    rd(dca_pkg::SH_INT_STAT, 32'h8f, "int status");
    cmp_word("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, dca_pkg::SH_INT_MASK, 32'h80);
    repeat (2) @(posedge mclk);
    cmp_word("irq raised", 32'h1, {31'h0, irq});
    bus(1'b1, dca_pkg::SH_INT_STAT, 32'h8f);
    repeat (2) @(posedge mclk);
    cmp_word("irq cleared", 32'h0, {31'h0, irq});
    rd(dca_pkg::SH_INT_STAT, 32'h0, "int status");
    // Half select on channel 3: event after the middle item only
    bus(1'b1, ra(3, 3'h0), 32'hf);
    expect_x(3, pb[3]);
    item(3);
    rd(dca_pkg::SH_INT_STAT, 32'h0, "int status");
    expect_x(3, pb[3] + 24'(1 << SH));
    item(3);
    rd(dca_pkg::SH_INT_STAT, 32'h8, "int status");
    // Peripheral request while the forced one is still pending
    expect_x(1, sb[1]);
    bus(1'b1, ra(1, 3'h0), 32'h10b);
    chan_req <= 4'h2;
    @(posedge mclk);
    chan_req <= 4'h0;
    wait_x();
    rd(dca_pkg::SH_REQ_COL, 32'h2, "request collision");
    finish_test();
  end
endmodule : dma_channel_address_status_bench
